// ### hdl/fcpc_top.v
// Common and per-port control register bank with decoded control outputs
`timescale 1ns/1ns
`include "fcpc_regs.vh"
module fcpc_top #(
    parameter [3:0] PRODUCT_VERSION = 4'h1, // Arbitrary value
    parameter [3:0] MAJOR_VERSION = 4'h1, // Arbitrary value
    parameter [3:0] MINOR_VERSION = 4'h0 // Arbitrary value
) (
    input wire core_clk,
    input wire rst_b,
    input wire reg_cs,
    input wire reg_wr,
    input wire [11:0] reg_addr,
    input wire [31:0] reg_wdata,
    output reg [31:0] reg_rdata,
    input wire [95:0] rx_alarm_events,
    output wire global_reset,
    output wire tx_synth_reset,
    output wire [3:0] rx_port_reset,
    output wire [3:0] tx_port_reset,
    output wire [7:0] gp_pin_out,
    output wire [7:0] gp_pin_oe,
    output wire [3:0] payload_type_select,
    output wire [3:0] equipment_loopback,
    output wire [3:0] eq_loop_line_out,
    output wire [3:0] eq_loop_send_ais,
    output wire [3:0] serdes_line_loopback,
    output wire [3:0] loop_timing,
    output wire [3:0] frame_align_enable,
    output wire [11:0] tx_insert_enable,
    output wire [11:0] rx_extract_enable,
    output wire [3:0] rx_alarm_pin_a,
    output wire [3:0] rx_alarm_pin_b
);

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    // Common window hit: strobe qualified by an exact byte address
    function fcpc_common_hit;
        input strobe;
        input [11:0] addr;
        input [11:0] want;
        begin
            fcpc_common_hit = strobe & (addr == want);
        end
    endfunction

    // Port window hit: strobe qualified by an offset inside the window
    function fcpc_port_hit;
        input strobe;
        input [9:0] off;
        input [9:0] want;
        begin
            fcpc_port_hit = strobe & (off == want);
        end
    endfunction

    // Port sub-reset: the global, all-port or own-port bit holds the port
    function fcpc_reset_mix;
        input glob;
        input all_ports;
        input one_port;
        begin
            fcpc_reset_mix = glob | all_ports | one_port;
        end
    endfunction

    // ------------------------------------------------------------
    // Common registers
    // ------------------------------------------------------------
    reg [31:0] gen_q;
    reg [31:0] soft_reset_control_q;
    reg [31:0] gp_output_level_q;
    reg [95:0] evt_s1_q;
    reg [95:0] evt_s2_q;
    wire wr_en;
    wire rd_en;
    wire gen_we;
    wire soft_reset_control_we;
    wire gp_output_level_we;
    wire [31:0] ver_word;
    reg [31:0] common_rd;

    // One access per strobed cycle; the write flag picks the direction
    assign wr_en = reg_cs & reg_wr;
    assign rd_en = reg_cs & ~reg_wr;
    // Version word, upper bits zero
    assign ver_word = {`FCPC_VER_PAD, PRODUCT_VERSION, MAJOR_VERSION, MINOR_VERSION};

    // Common write strobes; the read-only version offset has none
    assign gen_we = fcpc_common_hit(wr_en, reg_addr, `FCPC_OFF_GEN);
    assign soft_reset_control_we = fcpc_common_hit(wr_en, reg_addr, `FCPC_OFF_SOFT_RESET_CONTROL);
    assign gp_output_level_we = fcpc_common_hit(wr_en, reg_addr, `FCPC_OFF_GP_OUTPUT_LEVEL);

    // General mode keeps only the pin direction field
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            gen_q <= `FCPC_GEN_RST;
        else if (gen_we)
            gen_q <= reg_wdata & `FCPC_GEN_MASK;
    end

    // Soft reset bits hold until software writes them back to zero
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            soft_reset_control_q <= `FCPC_ZERO;
        else if (soft_reset_control_we)
            soft_reset_control_q <= reg_wdata & `FCPC_SOFT_RESET_CONTROL_MASK;
    end

    // Pin level bits, reserved bits masked off
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            gp_output_level_q <= `FCPC_ZERO;
        else if (gp_output_level_we)
            gp_output_level_q <= reg_wdata & `FCPC_GP_OUTPUT_LEVEL_MASK;
    end

    // Alarm events come from other logic domains, so synchronise
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            evt_s1_q <= `FCPC_EVT_RST;
            evt_s2_q <= `FCPC_EVT_RST;
        end
        else
        begin
            evt_s1_q <= rx_alarm_events;
            evt_s2_q <= evt_s1_q;
        end
    end

    // Soft reset outputs; global reset overrides all sub-resets
    assign global_reset = soft_reset_control_q[`FCPC_SOFT_RESET_CONTROL_ALL];
    assign tx_synth_reset = soft_reset_control_q[`FCPC_SOFT_RESET_CONTROL_PLL] | global_reset;

    // General-purpose pins: level only driven while set as output
    assign gp_pin_oe = gen_q[`FCPC_DIR_LSB +: `FCPC_GP_W];
    assign gp_pin_out = gp_output_level_q[`FCPC_GP_W-1:0] & gp_pin_oe;

    // Common read mux; unmapped common offsets read zero
    always @*
    begin
        common_rd = `FCPC_ZERO;
        case (reg_addr)
            `FCPC_OFF_GEN: common_rd = gen_q;
            `FCPC_OFF_SOFT_RESET_CONTROL: common_rd = soft_reset_control_q;
            `FCPC_OFF_VER: common_rd = ver_word;
            `FCPC_OFF_GP_OUTPUT_LEVEL: common_rd = gp_output_level_q;
            default: common_rd = `FCPC_ZERO;
        endcase
    end

    // ------------------------------------------------------------
    // Per-port registers
    // ------------------------------------------------------------
    wire [1:0] port_sel;
    wire [9:0] port_off;
    wire [127:0] port_rd;
    // Port number in the top address bits, register offset below
    assign port_sel = reg_addr[`FCPC_AW-1:`FCPC_PORT_LSB];
    assign port_off = reg_addr[`FCPC_PORT_LSB-1:0];

    // One register set per port
    genvar p;
    generate
        for (p = 0; p < `FCPC_NPORT; p = p + 1)
        begin : g_port
            // Local state of one port copy
            reg [31:0] pgen_q;
            reg [31:0] ptx_q;
            reg [31:0] prx_q;
            reg [31:0] alma_q;
            reg [31:0] almb_q;
            reg [31:0] rd;
            wire pwr;
            wire pgen_we;
            wire ptx_we;
            wire prx_we;
            wire alma_we;
            wire almb_we;
            wire [23:0] ev;
            wire [23:0] hit_a;
            wire [23:0] hit_b;
            // Each copy answers only its own port's window
            assign pwr = wr_en & (port_sel == p);
            assign ev = evt_s2_q[p*`FCPC_NALM +: `FCPC_NALM];

            // Register strobes; unmapped offsets write nothing
            assign pgen_we = fcpc_port_hit(pwr, port_off, `FCPC_OFF_PGEN);
            assign ptx_we = fcpc_port_hit(pwr, port_off, `FCPC_OFF_PTX);
            assign prx_we = fcpc_port_hit(pwr, port_off, `FCPC_OFF_PRX);
            assign alma_we = fcpc_port_hit(pwr, port_off, `FCPC_OFF_ALMA);
            assign almb_we = fcpc_port_hit(pwr, port_off, `FCPC_OFF_ALMB);

            // Port general mode; payload select leaves reset as one
            always @(posedge core_clk or negedge rst_b)
            begin
                if (!rst_b)
                    pgen_q <= `FCPC_PGEN_RST;
                else if (pgen_we)
                    pgen_q <= reg_wdata & `FCPC_PGEN_MASK;
            end

            // Transmit mode: frame alignment and insert interface enables
            always @(posedge core_clk or negedge rst_b)
            begin
                if (!rst_b)
                    ptx_q <= `FCPC_ZERO;
                else if (ptx_we)
                    ptx_q <= reg_wdata & `FCPC_PTX_MASK;
            end

            // Receive mode: extract interface enables
            always @(posedge core_clk or negedge rst_b)
            begin
                if (!rst_b)
                    prx_q <= `FCPC_ZERO;
                else if (prx_we)
                    prx_q <= reg_wdata & `FCPC_PRX_MASK;
            end

            // Alarm select A, one receive condition per bit
            always @(posedge core_clk or negedge rst_b)
            begin
                if (!rst_b)
                    alma_q <= `FCPC_ZERO;
                else if (alma_we)
                    alma_q <= reg_wdata & `FCPC_ALM_MASK;
            end

            // Alarm select B, one receive condition per bit
            always @(posedge core_clk or negedge rst_b)
            begin
                if (!rst_b)
                    almb_q <= `FCPC_ZERO;
                else if (almb_we)
                    almb_q <= reg_wdata & `FCPC_ALM_MASK;
            end

            // Receive and transmit resets: all-port, per-port, or global
            assign rx_port_reset[p] = fcpc_reset_mix(global_reset, soft_reset_control_q[`FCPC_SOFT_RESET_CONTROL_RXA],
                soft_reset_control_q[`FCPC_SOFT_RESET_CONTROL_RXP + p]);
            assign tx_port_reset[p] = fcpc_reset_mix(global_reset, soft_reset_control_q[`FCPC_SOFT_RESET_CONTROL_TXA],
                soft_reset_control_q[`FCPC_SOFT_RESET_CONTROL_TXP + p]);

            // Port mode decodes
            assign payload_type_select[p] = pgen_q[`FCPC_PG_APM];
            assign equipment_loopback[p] = pgen_q[`FCPC_PG_ELP];
            assign eq_loop_line_out[p] = pgen_q[`FCPC_PG_ELP] & pgen_q[`FCPC_PG_ELPO];
            assign eq_loop_send_ais[p] = pgen_q[`FCPC_PG_ELP] & ~pgen_q[`FCPC_PG_ELPO];
            assign serdes_line_loopback[p] = pgen_q[`FCPC_PG_SLLP];
            assign loop_timing[p] = pgen_q[`FCPC_PG_LPT];
            assign frame_align_enable[p] = ptx_q[`FCPC_PT_FPE];
            assign tx_insert_enable[p*`FCPC_EN_W +: `FCPC_EN_W] = ptx_q[`FCPC_EN_W-1:0];
            assign rx_extract_enable[p*`FCPC_EN_W +: `FCPC_EN_W] = prx_q[`FCPC_EN_W-1:0];

            // Synchronised conditions that the select registers pass on
            assign hit_a = ev & alma_q[`FCPC_NALM-1:0];
            assign hit_b = ev & almb_q[`FCPC_NALM-1:0];

            // Alarm pins: any selected condition present drives high
            assign rx_alarm_pin_a[p] = |hit_a;
            assign rx_alarm_pin_b[p] = |hit_b;

            // Per-port read mux; unmapped offsets read zero
            always @*
            begin
                rd = `FCPC_ZERO;
                case (port_off)
                    `FCPC_OFF_PGEN: rd = pgen_q;
                    `FCPC_OFF_PTX: rd = ptx_q;
                    `FCPC_OFF_PRX: rd = prx_q;
                    `FCPC_OFF_ALMA: rd = alma_q;
                    `FCPC_OFF_ALMB: rd = almb_q;
                    default: rd = `FCPC_ZERO;
                endcase
            end
            assign port_rd[p*32 +: 32] = rd;
        end
    endgenerate

    // ------------------------------------------------------------
    // Read data register
    // ------------------------------------------------------------
    wire [31:0] port_word;
    wire [31:0] common_word;
    // Selected port copy; common registers answer only in the port-0 window
    assign port_word = port_rd[port_sel*32 +: 32];
    assign common_word = (port_sel == 2'h0) ? common_rd : `FCPC_ZERO;

    // Read word is captured on the read cycle and held until the next read
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            reg_rdata <= `FCPC_ZERO;
        end
        else if (rd_en)
        begin
            reg_rdata <= port_word | common_word;
        end
    end

endmodule

// ### hdl/fcpc_regs.vh
// Register map, field positions and reset values of the common and per-port control bank
// Notes on behaviour
// - Global soft reset holds every function reset
// - Synth reset bit holds transmit clock synthesis
// - All-port receive reset holds every receiver
// - Per-port receive reset bits, bits eight..five
// - All-port transmit reset, synthesis keeps running
// - Per-port transmit reset bits three..zero, synth untouched
// - Version register: product, major, minor nibbles
// - Level bits drive pins when configured output
// - Payload select: one ATM, zero POS, reset one
// - Equipment loopback bit per port
// - Loop output bit sends data, else AIS
// - Serdes line loopback bit per port
// - Looptime bit selects recovered receive clock
// - Frame align enable uses external frame pulse
// - Transmit line DCC, section DCC, overhead enables
// - Receive line DCC, section DCC, overhead enables
// - Two alarm selects each drive own pin
// - Direction field: one output, zero input
// - Alarm select bit n maps condition n
`ifndef FCPC_REGS_VH
`define FCPC_REGS_VH
`define FCPC_AW 12
`define FCPC_OFF_GEN 12'h000
`define FCPC_OFF_SOFT_RESET_CONTROL 12'h008
`define FCPC_OFF_VER 12'h00c
`define FCPC_OFF_GP_OUTPUT_LEVEL 12'h010
`define FCPC_OFF_PGEN 10'h020
`define FCPC_OFF_PTX 10'h024
`define FCPC_OFF_PRX 10'h028
`define FCPC_OFF_ALMA 10'h02c
`define FCPC_OFF_ALMB 10'h030
`define FCPC_PORT_LSB 10
`define FCPC_GEN_MASK 32'h00ff0000
`define FCPC_GEN_RST 32'h00000000
`define FCPC_SOFT_RESET_CONTROL_MASK 32'h000107ff
`define FCPC_GP_OUTPUT_LEVEL_MASK 32'h000000ff
`define FCPC_PGEN_MASK 32'h00010a06
`define FCPC_PGEN_RST 32'h00010000
`define FCPC_PTX_MASK 32'h0000000f
`define FCPC_PRX_MASK 32'h00000007
`define FCPC_ALM_MASK 32'h00ffffff
`define FCPC_ZERO 32'h00000000
`define FCPC_DIR_LSB 16
`define FCPC_SOFT_RESET_CONTROL_ALL 16
`define FCPC_SOFT_RESET_CONTROL_PLL 10
`define FCPC_SOFT_RESET_CONTROL_RXA 9
`define FCPC_SOFT_RESET_CONTROL_RXP 5
`define FCPC_SOFT_RESET_CONTROL_TXA 4
`define FCPC_SOFT_RESET_CONTROL_TXP 0
`define FCPC_PG_APM 16
`define FCPC_PG_ELPO 11
`define FCPC_PG_ELP 9
`define FCPC_PG_SLLP 2
`define FCPC_PG_LPT 1
`define FCPC_PT_FPE 3
`define FCPC_NALM 24
`define FCPC_NPORT 4
`define FCPC_GP_W 8
`define FCPC_EN_W 3
`define FCPC_EVT_RST 96'h0
`define FCPC_VER_PAD 20'h00000
`endif

// ### sim/fcpc_props.sv
// Checker of the control bank port behaviour
`timescale 1ns/1ns
module fcpc_props (
    input wire core_clk,
    input wire rst_b,
    input wire reg_cs,
    input wire reg_wr,
    input wire [11:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire [31:0] reg_rdata,
    input wire [95:0] rx_alarm_events,
    input wire global_reset,
    input wire tx_synth_reset,
    input wire [3:0] rx_port_reset,
    input wire [3:0] tx_port_reset,
    input wire [7:0] gp_pin_out,
    input wire [7:0] gp_pin_oe,
    input wire [3:0] payload_type_select,
    input wire [3:0] equipment_loopback,
    input wire [3:0] eq_loop_line_out,
    input wire [3:0] eq_loop_send_ais,
    input wire [3:0] rx_alarm_pin_a
);
    // ----------
    // Properties
    // ----------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // Soft reset register write and port 1 alarm activity
    wire wr_soft_reset_control = reg_cs && reg_wr && reg_addr == 12'h008;
    wire ev1 = |rx_alarm_events[47:24];
    property p_global; global_reset |-> tx_synth_reset && &rx_port_reset && &tx_port_reset; endproperty
    a_global: assert property (p_global) else $error("global reset not spread");
    property p_synth; wr_soft_reset_control && !reg_wdata[10] && !reg_wdata[16] |=> !tx_synth_reset; endproperty
    a_synth: assert property (p_synth) else $error("synth reset without cause");
    property p_rxall; wr_soft_reset_control && reg_wdata[9] |=> rx_port_reset == 4'hf; endproperty
    a_rxall: assert property (p_rxall) else $error("rx all reset missing");
    property p_txall; wr_soft_reset_control && reg_wdata[4] |=> tx_port_reset == 4'hf; endproperty
    a_txall: assert property (p_txall) else $error("tx all reset missing");
    property p_pgen; reg_cs && reg_wr && reg_addr == 12'h420 |=> payload_type_select[1] == $past(reg_wdata[16])
        && equipment_loopback[1] == $past(reg_wdata[9]); endproperty
    a_pgen: assert property (p_pgen) else $error("port 1 mode not taken");
    property p_ais; eq_loop_send_ais == (equipment_loopback & ~eq_loop_line_out); endproperty
    a_ais: assert property (p_ais) else $error("ais choice wrong");
    property p_gp; (gp_pin_out & ~gp_pin_oe) == 8'h00; endproperty
    a_gp: assert property (p_gp) else $error("input pin driven");
    property p_ver; reg_cs && !reg_wr && reg_addr == 12'h00c |=> reg_rdata[31:12] == 20'h00000; endproperty
    a_ver: assert property (p_ver) else $error("version upper bits set");
    property p_alarm; rx_alarm_pin_a[1] |-> $past(ev1, 2); endproperty
    a_alarm: assert property (p_alarm) else $error("alarm pin without event");
endmodule
bind fcpc_top fcpc_props u_props (.core_clk(core_clk), .rst_b(rst_b), .reg_cs(reg_cs), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rx_alarm_events(rx_alarm_events),
    .global_reset(global_reset), .tx_synth_reset(tx_synth_reset), .rx_port_reset(rx_port_reset),
    .tx_port_reset(tx_port_reset), .gp_pin_out(gp_pin_out), .gp_pin_oe(gp_pin_oe),
    .payload_type_select(payload_type_select), .equipment_loopback(equipment_loopback),
    .eq_loop_line_out(eq_loop_line_out), .eq_loop_send_ais(eq_loop_send_ais), .rx_alarm_pin_a(rx_alarm_pin_a));

// ### sim/fcpc_alarm_src.sv
// Alarm condition source standing for the receive framing logic
`timescale 1ns/1ns
module fcpc_alarm_src (
    input wire core_clk,
    input wire [95:0] cond_req,
    output reg [95:0] rx_alarm_events
);
    // Conditions change just after a clock edge, as live detectors would
    initial rx_alarm_events = 96'h0;
    always @(posedge core_clk)
    begin
        rx_alarm_events <= cond_req;
    end
endmodule

// ### sim/fcpc_top_tb.sv
// Self-checking bench of the control bank through its register port
`timescale 1ns/1ns
module fcpc_top_tb;
    reg core_clk = 1'b0;
    reg rst_b = 1'b0;
    reg reg_cs = 1'b0;
    reg reg_wr = 1'b0;
    reg [11:0] reg_addr = 12'h000;
    reg [31:0] reg_wdata = 32'h00000000;
    reg [95:0] cond_req = 96'h0;
    reg [3:0] m;
    wire [95:0] ev;
    wire [31:0] rdata;
    wire glb, synth;
    wire [3:0] rxr, txr, pts, elp, elo, ais, sll, lpt, fae, pa, pb;
    wire [7:0] gpo, gpe;
    wire [11:0] tie, rxe;
    integer fails = 0;
    integer samples_checked = 0;
    integer p;
    // Clock, partner and unit
    always #2 core_clk = ~core_clk;
    fcpc_alarm_src u_src (.core_clk(core_clk), .cond_req(cond_req), .rx_alarm_events(ev));
    fcpc_top uut (.core_clk(core_clk), .rst_b(rst_b), .reg_cs(reg_cs), .reg_wr(reg_wr), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(rdata), .rx_alarm_events(ev), .global_reset(glb),
        .tx_synth_reset(synth), .rx_port_reset(rxr), .tx_port_reset(txr), .gp_pin_out(gpo), .gp_pin_oe(gpe),
        .payload_type_select(pts), .equipment_loopback(elp), .eq_loop_line_out(elo), .eq_loop_send_ais(ais),
        .serdes_line_loopback(sll), .loop_timing(lpt), .frame_align_enable(fae), .tx_insert_enable(tie),
        .rx_extract_enable(rxe), .rx_alarm_pin_a(pa), .rx_alarm_pin_b(pb));
    // -------------
    // Shared tasks
    // -------------
    task chk(input [31:0] seen, input [31:0] exp);
    begin
        samples_checked = samples_checked + 1;
        if (seen !== exp)
        begin
            fails = fails + 1;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    end
    endtask
    // One access cycle; results settle after the taking edge
    task acc(input w, input [11:0] a, input [31:0] d);
    begin
        @(posedge core_clk);
        reg_cs <= 1'b1;
        reg_wr <= w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_cs <= 1'b0;
        #1;
    end
    endtask
    task rd(input [11:0] a, input [31:0] exp);
    begin
        acc(1'b0, a, 32'h0);
        chk(rdata, exp);
    end
    endtask
    task report_and_stop;
    begin
        $display("compares %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    end
    endtask
    // Watchdog against a hang
    initial
    begin
        repeat (5000) @(posedge core_clk);
        fails = fails + 1;
        report_and_stop;
    end
    // --------
    // Tests
    // --------
    initial
    begin
        repeat (16) @(posedge core_clk);
        rst_b <= 1'b1;
        for (p = 0; p < 4; p = p + 1)
            rd(p * 12'h400 + 12'h020, 32'h00010000);
        rd(12'h00c, 32'h00000110);
        acc(1'b1, 12'h00c, 32'hffffffff);
        rd(12'h00c, 32'h00000110);
        rd(12'h100, 32'h0);
        $display("test reset values done");
        acc(1'b1, 12'h008, 32'hffffffff);
        rd(12'h008, 32'h000107ff);
        chk({glb, synth, rxr, txr}, 10'h3ff);
        for (p = 0; p < 4; p = p + 1)
        begin
            acc(1'b1, 12'h008, 32'h21 << p);
            chk({synth, rxr, txr}, {1'b0, 4'h1 << p, 4'h1 << p});
        end
        acc(1'b1, 12'h008, 32'h200);
        chk({synth, rxr, txr}, 9'h0f0);
        acc(1'b1, 12'h008, 32'h010);
        chk({synth, rxr, txr}, 9'h00f);
        acc(1'b1, 12'h008, 32'h400);
        chk({synth, rxr, txr}, 9'h100);
        acc(1'b1, 12'h008, 32'h0);
        acc(1'b1, 12'h000, 32'hff0f0000);
        acc(1'b1, 12'h010, 32'hffffffff);
        chk({gpe, gpo}, 16'h0f0f);
        rd(12'h010, 32'h000000ff);
        $display("test resets and pins done");
        for (p = 0; p < 4; p = p + 1)
        begin
            m = 4'h1 << p;
            acc(1'b1, p * 12'h400 + 12'h020, 32'hfffeffff);
            rd(p * 12'h400 + 12'h020, 32'h00000a06);
            chk({pts, elp, elo, ais, sll, lpt}, {~m, m, m, 4'h0, m, m});
            acc(1'b1, p * 12'h400 + 12'h020, 32'h00010200);
            chk({elo, ais}, {4'h0, m});
            acc(1'b1, p * 12'h400 + 12'h020, 32'h00010000);
            acc(1'b1, p * 12'h400 + 12'h024, 32'hffffffff);
            acc(1'b1, p * 12'h400 + 12'h028, 32'hffffffff);
            chk({fae, tie, rxe}, {m, 12'h7 << (3 * p), 12'h7 << (3 * p)});
            acc(1'b1, p * 12'h400 + 12'h024, 32'h0);
            acc(1'b1, p * 12'h400 + 12'h028, 32'h0);
        end
        $display("test port modes done");
        acc(1'b1, 12'h42c, 32'hffffffff);
        rd(12'h42c, 32'h00ffffff);
        acc(1'b1, 12'h42c, 32'h00000020);
        acc(1'b1, 12'h430, 32'h00800000);
        @(posedge core_clk);
        cond_req <= (96'h10 << 24) | 96'h20;
        repeat (4) @(posedge core_clk);
        #1;
        chk({pa, pb}, 8'h00);
        @(posedge core_clk);
        cond_req <= 96'h800020 << 24;
        repeat (4) @(posedge core_clk);
        #1;
        chk({pa, pb}, 8'h22);
        $display("test alarm pins done");
        report_and_stop;
    end
endmodule
